/* File: common/freeze_pkg.sv */
/*
  package for the timer freeze control block: register addresses, field positions,
  reset values and the carrier structs of the register port and the hold outputs.
  assumes a 16-bit register port with word-wide accesses at the printed addresses.
*/
package freeze_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 16;
  localparam logic [31:0] FREEZE_SET_ADDR     = 32'h5000_3300;
  localparam logic [31:0] FREEZE_RELEASE_ADDR = 32'h5000_3302;
  localparam logic [31:0] HALT_CTRL_ADDR      = 32'h5000_3304;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned UNIT_N          = 5;
  localparam int unsigned WAKEUP_BIT      = 0;
  localparam int unsigned SWTIMER_BIT     = 1;
  localparam int unsigned RADIO_BIT       = 2;
  localparam int unsigned WATCHDOG_BIT    = 3;
  localparam int unsigned DMA_BIT         = 4;
  localparam int unsigned AUTO_HOLD_BIT   = 0;
  localparam logic [4:0]  HOLD_RESET      = 5'h00;
  localparam logic        AUTO_HOLD_RESET = 1'h1;
  localparam logic [15:0] READ_UNMAPPED   = 16'h0000;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic dma_hold;
    logic watchdog_hold;
    logic radio_timebase_hold;
    logic software_timer_hold;
    logic wakeup_timer_hold;
  } hold_out_t;

endpackage

/* File: hdl/hold_bit.sv */
/*
  one freeze state bit with separate write-one-to-set and write-one-to-release strokes.
  assumes strokes are one-cycle pulses from the register decode.
*/
`timescale 1ns/1ps
`default_nettype none
module hold_bit (
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  input  wire logic i_set,
  input  wire logic i_release,
  output logic      o_hold
);

  typedef struct packed {
    logic hold;
  } bit_state_t;

  bit_state_t state_q;
  bit_state_t state_d;

  always_comb begin
    state_d = state_q;
    if (i_release) begin
      state_d.hold = 1'b0;
    end
    if (i_set) begin
      state_d.hold = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_hold = state_q.hold;

endmodule
`default_nettype wire

/* File: hdl/timer_freeze_control.sv */
/*
  timer freeze control: software freeze state for dma, watchdog, radio timebase,
  software timer and wake-up timer, plus automatic hold while the cpu is halted.
  assumes a single-cycle register port with read data one cycle later, and
  i_cpu_halted / i_watchdog_reset_select synchronous to i_clk_sys.
*/
// Behaviour
// - freeze set register sits at 0x50003300 and sets freeze bits.
// - freeze release register sits at 0x50003302 and clears freeze bits.
// - bit 4 one in set freezes dma; zero ignored.
// - bit 3 one in set freezes watchdog; zero ignored.
// - software (bit 3) watchdog freeze acts only while watchdog reset-select bit is zero.
// - bit 2 one in set stops radio timebase; zero ignored.
// - bit 1 one in set freezes software timer; zero ignored.
// - bit 0 one in set freezes wake-up timer; zero ignored.
// - bit 4 one in release resumes dma; zero ignored.
// - bit 3 one in release resumes watchdog; zero ignored.
// - bit 2 one in release restarts radio timebase; zero ignored.
// - bit 1 one in release resumes software timer; zero ignored.
// - bit 0 one in release resumes wake-up timer; zero ignored.
// - cpu halt freezes all when auto-hold enabled; else software state, watchdog always.
`timescale 1ns/1ps
`default_nettype none
module timer_freeze_control (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_reset_n,
  input  wire logic [freeze_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [freeze_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  input  wire logic                          i_cpu_halted,
  input  wire logic                          i_watchdog_reset_select,
  output logic [freeze_pkg::DATA_W-1:0]      o_rdata,
  output logic                               o_halt_auto_hold_enable,
  output freeze_pkg::hold_out_t              o_hold
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [freeze_pkg::DATA_W-1:0] rdata;
    logic                          auto_hold_en;
    freeze_pkg::hold_out_t         hold;
  } ctrl_state_t;

  ctrl_state_t                  state_q;
  ctrl_state_t                  state_d;
  freeze_pkg::reg_req_t         req;
  logic [freeze_pkg::UNIT_N-1:0] set_stroke;
  logic [freeze_pkg::UNIT_N-1:0] release_stroke;
  logic [freeze_pkg::UNIT_N-1:0] sw_hold;
  logic                          hit_set;
  logic                          hit_release;
  logic                          hit_halt;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  assign hit_set     = (req.addr == freeze_pkg::FREEZE_SET_ADDR);
  assign hit_release = (req.addr == freeze_pkg::FREEZE_RELEASE_ADDR);
  assign hit_halt    = (req.addr == freeze_pkg::HALT_CTRL_ADDR);

  // only bits 4:0 stroke; upper bits dropped here
  assign set_stroke     = (req.wr && hit_set) ? req.wdata[freeze_pkg::UNIT_N-1:0] : '0;
  assign release_stroke = (req.wr && hit_release) ? req.wdata[freeze_pkg::UNIT_N-1:0] : '0;

  // ----------------------------------------------------------------------
  // freeze state bits
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < freeze_pkg::UNIT_N; g++) begin : g_unit
      hold_bit u_hold_bit (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_set     (set_stroke[g]),
        .i_release (release_stroke[g]),
        .o_hold    (sw_hold[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // next state: read port, halt control, effective holds
  // ----------------------------------------------------------------------
  always_comb begin
    state_d       = state_q;
    state_d.rdata = freeze_pkg::READ_UNMAPPED;
    if (req.rd) begin
      if (hit_set || hit_release) begin
        state_d.rdata = {11'h000, sw_hold};
      end else if (hit_halt) begin
        state_d.rdata = {15'h0000, state_q.auto_hold_en};
      end
    end
    if (req.wr && hit_halt) begin
      state_d.auto_hold_en = req.wdata[freeze_pkg::AUTO_HOLD_BIT];
    end
    state_d.hold.dma_hold            = sw_hold[freeze_pkg::DMA_BIT];
    state_d.hold.radio_timebase_hold = sw_hold[freeze_pkg::RADIO_BIT];
    state_d.hold.software_timer_hold = sw_hold[freeze_pkg::SWTIMER_BIT];
    state_d.hold.wakeup_timer_hold   = sw_hold[freeze_pkg::WAKEUP_BIT];
    // software watchdog freeze needs reset-select at zero
    state_d.hold.watchdog_hold = sw_hold[freeze_pkg::WATCHDOG_BIT] && !i_watchdog_reset_select;
    if (i_cpu_halted) begin
      state_d.hold.watchdog_hold = 1'b1;
      if (state_q.auto_hold_en) begin
        state_d.hold = '1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      state_q <= '{rdata:        freeze_pkg::READ_UNMAPPED,
                   auto_hold_en: freeze_pkg::AUTO_HOLD_RESET,
                   hold:         freeze_pkg::HOLD_RESET};
    end else begin
      state_q <= state_d;
    end
  end

  assign o_rdata                 = state_q.rdata;
  assign o_halt_auto_hold_enable = state_q.auto_hold_en;
  assign o_hold                  = state_q.hold;

endmodule
`default_nettype wire

/* File: test/freeze_checker.sv */
/* checker for timer_freeze_control port behaviour.
   assumes it sees only the top ports, bound below. */
`timescale 1ns/1ps
`default_nettype none
module freeze_checker (
  input wire logic                          i_clk_sys,
  input wire logic                          i_reset_n,
  input wire logic [freeze_pkg::ADDR_W-1:0] i_addr,
  input wire logic [freeze_pkg::DATA_W-1:0] i_wdata,
  input wire logic                          i_wr,
  input wire logic                          i_rd,
  input wire logic                          i_cpu_halted,
  input wire logic                          i_watchdog_reset_select,
  input wire logic [freeze_pkg::DATA_W-1:0] o_rdata,
  input wire logic                          o_halt_auto_hold_enable,
  input wire freeze_pkg::hold_out_t         o_hold
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic set_w;
  logic rel_w;
  assign set_w = i_wr && i_addr == freeze_pkg::FREEZE_SET_ADDR;
  assign rel_w = i_wr && i_addr == freeze_pkg::FREEZE_RELEASE_ADDR;
  property p_set_dma; set_w && i_wdata[4] |-> ##2 o_hold.dma_hold; endproperty
  a_set_dma: assert property (p_set_dma) else $error("dma hold not set");
  property p_set_wd; set_w && i_wdata[3] && !i_watchdog_reset_select ##1 !i_watchdog_reset_select
    |-> ##1 o_hold.watchdog_hold; endproperty
  a_set_wd: assert property (p_set_wd) else $error("watchdog hold not set");
  property p_wd_mask; (i_watchdog_reset_select && !i_cpu_halted)[*2] |=> !o_hold.watchdog_hold; endproperty
  a_wd_mask: assert property (p_wd_mask) else $error("watchdog hold while reset mode");
  property p_radio_keep; (!(i_wr && i_wdata[2]) && !i_cpu_halted)[*3] |-> $stable(o_hold.radio_timebase_hold);
  endproperty
  a_radio_keep: assert property (p_radio_keep) else $error("radio hold moved without a one");
  property p_rel_dma; rel_w && i_wdata[4] ##1 !i_cpu_halted |-> ##1 !o_hold.dma_hold; endproperty
  a_rel_dma: assert property (p_rel_dma) else $error("dma hold not released");
  property p_auto; (i_cpu_halted && o_halt_auto_hold_enable)[*2] |=> o_hold == 5'h1f; endproperty
  a_auto: assert property (p_auto) else $error("halt did not hold all");
  property p_wd_halt; i_cpu_halted[*2] |=> o_hold.watchdog_hold; endproperty
  a_wd_halt: assert property (p_wd_halt) else $error("halt did not hold watchdog");
  property p_rd_state; i_rd && i_addr == freeze_pkg::FREEZE_SET_ADDR && !i_cpu_halted && !i_watchdog_reset_select
    |=> o_rdata == {11'h000, o_hold}; endproperty
  a_rd_state: assert property (p_rd_state) else $error("readback differs from state");
  property p_rd_idle; !i_rd |=> o_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule
bind timer_freeze_control freeze_checker u_chk (.i_clk_sys, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_cpu_halted, .i_watchdog_reset_select, .o_rdata, .o_halt_auto_hold_enable, .o_hold);
`default_nettype wire

/* File: test/tb_timer_freeze_control.sv */
/* bench for timer_freeze_control: register accesses and halt inputs.
   assumes package, design and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_timer_freeze_control;
  localparam logic [31:0] SA = freeze_pkg::FREEZE_SET_ADDR;
  localparam logic [31:0] RA = freeze_pkg::FREEZE_RELEASE_ADDR;
  logic                  i_clk_sys = 1'b0;
  logic                  i_reset_n = 1'b0;
  logic                  i_wr = 1'b0;
  logic                  i_rd = 1'b0;
  logic                  i_cpu_halted = 1'b0;
  logic                  i_watchdog_reset_select = 1'b0;
  logic [31:0]           i_addr = 32'h0;
  logic [15:0]           i_wdata = 16'h0;
  logic [15:0]           o_rdata;
  logic                  o_halt_auto_hold_enable;
  freeze_pkg::hold_out_t o_hold;
  int                    n_errors = 0;
  int                    n_tests = 0;
  int                    cyc = 0;
  timer_freeze_control u_dut (.i_clk_sys, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_cpu_halted,
    .i_watchdog_reset_select, .o_rdata, .o_halt_auto_hold_enable, .o_hold);
  initial forever #5 i_clk_sys = ~i_clk_sys;
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(logic [31:0] a, logic [15:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [31:0] a, logic [15:0] e);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk("rdata", o_rdata, e);
  endtask
  task automatic hq(logic [4:0] e);
    repeat (2) @(posedge i_clk_sys);
    #1 chk("hold", {11'h000, o_hold}, {11'h000, e});
  endtask
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    #1 chk("auto_en", {15'h0000, o_halt_auto_hold_enable}, 16'h0001);
    hq(5'h00);
    rd(SA, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(SA, 16'h0001 << i);
      hq(5'((16'h0002 << i) - 16'h0001));
      rd(SA, (16'h0002 << i) - 16'h0001);
    end
    wr(SA, 16'hffe0);
    rd(RA, 16'h001f);
    for (int i = 0; i < 5; i++) begin
      wr(RA, 16'h0001 << i);
      hq(5'(16'h001f & ~((16'h0002 << i) - 16'h0001)));
    end
    wr(32'h5000_3306, 16'h001f);
    rd(32'h5000_3306, 16'h0000);
    @(posedge i_clk_sys) i_watchdog_reset_select <= 1'b1;
    wr(SA, 16'h0008);
    hq(5'h00);
    wr(RA, 16'h0008);
    @(posedge i_clk_sys) i_watchdog_reset_select <= 1'b0;
    i_cpu_halted <= 1'b1;
    hq(5'h1f);
    rd(SA, 16'h0000);
    rd(freeze_pkg::HALT_CTRL_ADDR, 16'h0001);
    wr(freeze_pkg::HALT_CTRL_ADDR, 16'hfffe);
    hq(5'h08);
    chk("auto_en", {15'h0000, o_halt_auto_hold_enable}, 16'h0000);
    rd(freeze_pkg::HALT_CTRL_ADDR, 16'h0000);
    wr(SA, 16'h0001);
    hq(5'h09);
    @(posedge i_clk_sys) i_cpu_halted <= 1'b0;
    wr(RA, 16'h0001);
    hq(5'h00);
    wr(SA, 16'h001f);
    @(posedge i_clk_sys) i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    #1 chk("auto_en", {15'h0000, o_halt_auto_hold_enable}, 16'h0001);
    hq(5'h00);
    rd(RA, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
